// ==== pkg/dhbp_map.vh ====
// Constants for the dual style host bus port
`ifndef DHBP_MAP_VH
`define DHBP_MAP_VH
`define DHBP_DATA_W      8
`define DHBP_ADDR_W      3
`define DHBP_CHAN_W      2
`define DHBP_CS_W        4
`define DHBP_SYNC_W      18
// Style, strobes and selects idle high; address and data low
`define DHBP_SYNC_INIT   18'h3F800
`define DHBP_STYLE_SEP   1'b1
`define DHBP_DIR_READ    1'b1
`define DHBP_CHAN_FIRST  2'h0
`define DHBP_CHAN_SECOND 2'h1
`define DHBP_CHAN_THIRD  2'h2
`define DHBP_CHAN_FOURTH 2'h3
`define DHBP_BYTE_ZERO   8'h00
`define DHBP_ADDR_ZERO   3'h0
// Bit positions inside the synchronised pin vector
`define DHBP_POS_DATA_LO 0
`define DHBP_POS_DATA_HI 7
`define DHBP_POS_ADDR_LO 8
`define DHBP_POS_ADDR_HI 10
`define DHBP_POS_CS_LO   11
`define DHBP_POS_CS_HI   14
`define DHBP_POS_WR      15
`define DHBP_POS_RD      16
`define DHBP_POS_STYLE   17
`endif

// ==== design/dhbp_pin_sync.v ====
// Two-stage synchroniser for the host bus pins
`timescale 1ns/1ps
`default_nettype none
module dhbp_pin_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             clk_sys,
  input  wire             arst_n,
  input  wire             clkEn,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinSync
);
  reg [WIDTH-1:0] meta_r;

  // Stage one feeds stage two only
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_r  <= INIT;
      pinSync <= INIT;
    end else if (clkEn) begin
      meta_r  <= pinIn;
      pinSync <= meta_r;
    end
  end
endmodule // dhbp_pin_sync
`default_nettype wire

// ==== design/dhbp_host_port.v ====
// Host bus port: pin decode, strobe edges, register access requests
`timescale 1ns/1ps
`default_nettype none
`include "dhbp_map.vh"
module dhbp_host_port (
  input  wire                     clk_sys,
  input  wire                     arst_n,
  input  wire                     clkEn,
  // Host pins
  input  wire                     busStyleSel,
  input  wire                     read_strobe_n,
  input  wire                     write_strobe_n,
  input  wire                     chan_first_select_n,
  input  wire                     chan_second_select_n,
  input  wire                     chan_third_select_n,
  input  wire                     chan_fourth_select_n,
  input  wire [`DHBP_ADDR_W-1:0]  hostAddr,
  input  wire [`DHBP_DATA_W-1:0]  hostDataIn,
  output reg  [`DHBP_DATA_W-1:0]  hostDataOut,
  output reg                      hostDataOe_n,
  // Channel register side
  output reg                      regRdReq,
  output reg                      regWrReq,
  output reg  [`DHBP_CHAN_W-1:0]  regChan,
  output reg  [`DHBP_ADDR_W-1:0]  regAddr,
  output reg  [`DHBP_DATA_W-1:0]  regWrData,
  input  wire [`DHBP_DATA_W-1:0]  regRdData
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_READ = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  wire [`DHBP_SYNC_W-1:0] pinSync;
  reg  [1:0]              state_r;
  reg  [1:0]              state_nxt;
  reg                     rdPrev_r;
  reg                     wrPrev_r;
  reg                     csPrev_r;
  reg  [`DHBP_CHAN_W-1:0] chanHeld_r;
  reg  [`DHBP_ADDR_W-1:0] addrHeld_r;

  // Pins come from another domain
  dhbp_pin_sync #(
    .WIDTH (`DHBP_SYNC_W),
    .INIT  (`DHBP_SYNC_INIT)
  ) uSync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .clkEn   (clkEn),
    .pinIn   ({busStyleSel, read_strobe_n, write_strobe_n,
               chan_fourth_select_n, chan_third_select_n,
               chan_second_select_n, chan_first_select_n,
               hostAddr, hostDataIn}),
    .pinSync (pinSync)
  );

  wire                    styleSep = pinSync[`DHBP_POS_STYLE];
  wire                    rdN      = pinSync[`DHBP_POS_RD];
  wire                    wrN      = pinSync[`DHBP_POS_WR];
  wire [`DHBP_CS_W-1:0]   csN      =
    pinSync[`DHBP_POS_CS_HI:`DHBP_POS_CS_LO];
  wire [`DHBP_ADDR_W-1:0] addrS    =
    pinSync[`DHBP_POS_ADDR_HI:`DHBP_POS_ADDR_LO];
  wire [`DHBP_DATA_W-1:0] dataS    =
    pinSync[`DHBP_POS_DATA_HI:`DHBP_POS_DATA_LO];

  // Channel decode for both styles; top bit flags a selected channel
  function [`DHBP_CHAN_W:0] chanDecode;
    input                  sep;
    input [`DHBP_CS_W-1:0] cs;
    begin
      if (sep == `DHBP_STYLE_SEP) begin
        // Lowest select wins if the host drops several at once
        if (!cs[0])
          chanDecode = {1'b1, `DHBP_CHAN_FIRST};
        else if (!cs[1])
          chanDecode = {1'b1, `DHBP_CHAN_SECOND};
        else if (!cs[2])
          chanDecode = {1'b1, `DHBP_CHAN_THIRD};
        else if (!cs[3])
          chanDecode = {1'b1, `DHBP_CHAN_FOURTH};
        else
          chanDecode = {1'b0, `DHBP_CHAN_FIRST};
      end else begin
        // Fourth select is not looked at here
        chanDecode = {~cs[0], cs[2], cs[1]};
      end
    end
  endfunction

  wire [`DHBP_CHAN_W:0]   decoded = chanDecode(styleSep, csN);
  wire                    chanHit = decoded[`DHBP_CHAN_W];
  wire [`DHBP_CHAN_W-1:0] chanNow = decoded[`DHBP_CHAN_W-1:0];

  // Separate-strobe style events
  wire sepRdStart = styleSep & chanHit & rdPrev_r & ~rdN;
  wire sepRdLive  = chanHit & ~rdN;
  wire sepWrEnd   = styleSep & chanHit & ~wrPrev_r & wrN;
  // Direction-line style: select is the strobe, write line the direction
  wire dirRead    = wrN == `DHBP_DIR_READ;
  wire dirRdStart = ~styleSep & chanHit & csPrev_r & dirRead;
  wire dirRdLive  = chanHit & dirRead;
  wire dirWrEnd   = ~styleSep & ~csPrev_r & ~chanHit & ~dirRead;
  wire rdStart    = sepRdStart | dirRdStart;
  wire rdLive     = styleSep ? sepRdLive : dirRdLive;
  wire wrEnd      = sepWrEnd | dirWrEnd;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rdStart)
          state_nxt = ST_READ;
      end
      ST_READ: begin
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        // Read ends when the strobe or select lifts, or in direction style when the write line drops
        if (!rdLive)
          state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= ST_IDLE;
      rdPrev_r     <= 1'b1;
      wrPrev_r     <= 1'b1;
      csPrev_r     <= 1'b1;
      chanHeld_r   <= `DHBP_CHAN_FIRST;
      addrHeld_r   <= `DHBP_ADDR_ZERO;
      hostDataOut  <= `DHBP_BYTE_ZERO;
      hostDataOe_n <= 1'b1;
      regRdReq     <= 1'b0;
      regWrReq     <= 1'b0;
      regChan      <= `DHBP_CHAN_FIRST;
      regAddr      <= `DHBP_ADDR_ZERO;
      regWrData    <= `DHBP_BYTE_ZERO;
    end else if (clkEn) begin
      state_r  <= state_nxt;
      rdPrev_r <= rdN;
      wrPrev_r <= wrN;
      csPrev_r <= ~chanHit;
      regRdReq <= 1'b0;
      regWrReq <= 1'b0;
      // Direction style keeps the address seen while selected,
      // since the select rising removes the channel decode
      if (chanHit) begin
        chanHeld_r <= chanNow;
        addrHeld_r <= addrS;
      end
      if (rdStart) begin
        regRdReq <= 1'b1;
        regChan  <= chanNow;
        regAddr  <= addrS;
      end
      if (wrEnd) begin
        regWrReq  <= 1'b1;
        regChan   <= styleSep ? chanNow : chanHeld_r;
        regAddr   <= styleSep ? addrS : addrHeld_r;
        regWrData <= dataS;
      end
      // Read data taken the cycle the request stands
      if (state_r == ST_READ)
        hostDataOut <= regRdData;
      // Drive from the request cycle so the byte is on the bus well
      // before the host's rising edge; bounded by the read only
      hostDataOe_n <= ~((state_nxt == ST_READ) |
                        (state_nxt == ST_WAIT));
    end
  end
endmodule // dhbp_host_port
`default_nettype wire

// ==== verif/dhbp_host_port_chk.sv ====
// Port-level assertions for the host bus port
`timescale 1ns/1ps
`default_nettype none
module dhbp_host_port_chk (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       chan_first_select_n,
  input wire logic       chan_second_select_n,
  input wire logic       chan_third_select_n,
  input wire logic       chan_fourth_select_n,
  input wire logic [7:0] hostDataOut,
  input wire logic       hostDataOe_n,
  input wire logic       regRdReq,
  input wire logic       regWrReq,
  input wire logic [7:0] regRdData
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire idleSel = chan_first_select_n & chan_second_select_n
    & chan_third_select_n & chan_fourth_select_n;
  a_rd_pulse: assert property (regRdReq |=> !regRdReq)
    else $error("read request too long");
  a_wr_pulse: assert property (regWrReq |=> !regWrReq)
    else $error("write request too long");
  a_rd_drive: assert property ($rose(regRdReq) |-> !hostDataOe_n)
    else $error("read without bus drive");
  a_oe_cause: assert property ($fell(hostDataOe_n) |-> regRdReq)
    else $error("bus driven without read");
  a_rd_data: assert property (regRdReq |=> hostDataOut == $past(regRdData))
    else $error("read byte not on bus");
  a_dout_hold: assert property (!$past(regRdReq) |-> $stable(hostDataOut))
    else $error("bus byte changed");
  a_no_select: assert property (idleSel[*8] |-> !regRdReq && !regWrReq)
    else $error("request with no select");
  a_oe_release: assert property (idleSel[*6] |-> hostDataOe_n)
    else $error("bus driven while idle");
  c_read: cover property (regRdReq);
  c_write: cover property (regWrReq);
  c_drive: cover property ($fell(hostDataOe_n));
endmodule // dhbp_host_port_chk
`default_nettype wire

// ==== verif/dhbp_host_model.sv ====
// Host processor model for the bus pins
`timescale 1ns/1ps
`default_nettype none
module dhbp_host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] busLevel,
  output var  logic       styleSel,
  output var  logic       rdN,
  output var  logic       wrN,
  output var  logic [3:0] csN,
  output var  logic [2:0] addr,
  output var  logic [7:0] drvData,
  output var  logic       drvOe,
  output var  logic [7:0] rdByte
);
  initial {styleSel, rdN, wrN, csN, addr, drvData, drvOe, rdByte} = 27'h7F00000;
  // Dir style holds the read strobe low on purpose: it must be ignored
  task automatic xfer(input logic sep, rd, noSel, input logic [1:0] ch,
                      input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    styleSel = sep;
    addr = a;
    drvData = d;
    drvOe = !rd;
    wrN = sep | rd;
    rdN = sep;
    csN = sep ? (noSel ? 4'hF : ~(4'h1 << ch)) : {~ch[0], ch[1], ch[0], 1'b1};
    @(negedge clk_sys);
    if (sep && rd) rdN = 1'b0;
    else if (sep) wrN = 1'b0;
    else csN[0] = noSel;
    repeat (6) @(negedge clk_sys);
    rdByte = busLevel;
    if (sep) {rdN, wrN} = 2'h3;
    else csN[0] = 1'b1;
    // Hold address and data past the rise for the synchroniser
    repeat (2) @(negedge clk_sys);
    {rdN, wrN, csN, drvOe} = 7'h7E;
    repeat (5) @(negedge clk_sys);
  endtask
endmodule // dhbp_host_model
`default_nettype wire

// ==== verif/dual_style_host_bus_port_test.sv ====
// Self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none
module dual_style_host_bus_port_test;
  logic clk_sys = 1'b0, arst_n = 1'b0, styleSel, rdN, wrN, drvOe, oeN;
  logic rdReq, wrReq;
  logic clkEn = 1'b1;
  logic [3:0] csN;
  logic [2:0] addr, regAddr;
  logic [1:0] regChan;
  logic [7:0] drvData, rdByte, dOut, wrData, floatPat = 8'h5A;
  logic [12:0] lastWr;
  int num_errors = 0, checked = 0, numRd = 0, numWr = 0;
  // Released bus toggles so a stale byte can never be read back
  wire [7:0] busLevel = !oeN ? dOut : drvOe ? drvData : floatPat;
  wire [7:0] rdData = {regChan, 3'h5, regAddr};
  always #4 clk_sys = ~clk_sys;
  dhbp_host_port i_dut (.clk_sys, .arst_n, .clkEn, .busStyleSel(styleSel),
    .read_strobe_n(rdN), .write_strobe_n(wrN), .chan_first_select_n(csN[0]),
    .chan_second_select_n(csN[1]), .chan_third_select_n(csN[2]),
    .chan_fourth_select_n(csN[3]), .hostAddr(addr), .hostDataIn(busLevel),
    .hostDataOut(dOut), .hostDataOe_n(oeN), .regRdReq(rdReq),
    .regWrReq(wrReq), .regChan, .regAddr, .regWrData(wrData),
    .regRdData(rdData));
  dhbp_host_model i_host (.clk_sys, .busLevel, .styleSel, .rdN, .wrN, .csN,
    .addr, .drvData, .drvOe, .rdByte);
  task automatic chk(input string what, input logic [12:0] exp, got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(negedge clk_sys) begin
    floatPat <= ~floatPat;
    if (rdReq === 1'b1) numRd++;
    if (wrReq === 1'b1) lastWr <= {regChan, regAddr, wrData};
    if (wrReq === 1'b1) numWr++;
    if (drvOe) chk("bus clash", 13'h1, {12'h0, oeN});
  end
  task automatic run(input logic sep, rd, noSel, input logic [1:0] ch,
                     input logic [2:0] a);
    int r0, w0;
    r0 = numRd;
    w0 = numWr;
    i_host.xfer(sep, rd, noSel, ch, a, {ch, a, ~a});
    chk("reads", 13'(r0 + int'(rd && !noSel)), 13'(numRd));
    chk("writes", 13'(w0 + int'(!rd && !noSel)), 13'(numWr));
    if (!noSel && rd)
      chk("read byte", {5'h0, ch, 3'h5, a}, {5'h0, rdByte});
    if (!noSel && !rd) chk("write", {ch, a, ch, a, ~a}, lastWr);
  endtask
  task automatic sepSweep();
    for (int c = 0; c < 4; c++) begin
      run(1'b1, 1'b0, 1'b0, 2'(c), 3'(7 - 2 * c));
      run(1'b1, 1'b1, 1'b0, 2'(c), 3'(7 - 2 * c));
    end
    $display("separate-strobe sweep finished");
  endtask
  task automatic dirSweep();
    for (int c = 0; c < 4; c++) begin
      run(1'b0, 1'b0, 1'b0, 2'(c), 3'(2 * c));
      run(1'b0, 1'b1, 1'b0, 2'(c), 3'(2 * c));
    end
    $display("direction-line sweep finished");
  endtask
  task automatic refusedCases();
    run(1'b1, 1'b1, 1'b1, 2'h0, 3'h2);
    run(1'b1, 1'b0, 1'b1, 2'h0, 3'h2);
    run(1'b0, 1'b1, 1'b1, 2'h1, 3'h2);
    $display("refused cases finished");
  endtask
  // Enable low freezes the pin stages too, so a whole write is lost
  task automatic freezeCase();
    int w0;
    w0 = numWr;
    clkEn = 1'b0;
    i_host.xfer(1'b1, 1'b0, 1'b0, 2'h1, 3'h4, 8'hC3);
    clkEn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("frozen writes", 13'(w0), 13'(numWr));
    $display("clock-enable freeze finished");
  endtask
  task automatic tally_and_finish();
    $display("%0d checks, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    sepSweep();
    dirSweep();
    refusedCases();
    freezeCase();
    tally_and_finish();
  end
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end
endmodule // dual_style_host_bus_port_test
bind dhbp_host_port dhbp_host_port_chk i_chk (.clk_sys, .arst_n,
  .chan_first_select_n, .chan_second_select_n, .chan_third_select_n,
  .chan_fourth_select_n, .hostDataOut, .hostDataOe_n, .regRdReq,
  .regWrReq, .regRdData);
`default_nettype wire
